// ---- hdl/ibms_slave.sv ----
// Purpose: two-wire serial slave in front of an 8192 byte memory
// Assumes: serial clock and data arrive as pins, sampled by clk
// Notes: writes pass through a small FIFO into the flip-flop array
`timescale 1ns/1ps
`default_nettype none
`include "ibms_cfg.svh"
module ibms_slave (
    input wire logic clk, // 10 MHz system clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic scl, // Serial clock pin from master
    input wire logic sda_in, // Serial data pin level
    output logic sda_out, // Serial data drive value, always low
    output logic sda_oe, // High while pulling data low
    input wire logic select_strap_bit0, // Address strap, lowest
    input wire logic select_strap_bit1, // Address strap, middle
    input wire logic select_strap_bit2, // Address strap, highest
    input wire logic write_lock, // High blocks array writes
    output logic busy // High outside standby
);
    // ***************************************
    // Declarations
    // ***************************************
    ibms_pkg::ibms_state_t state;
    ibms_pkg::ibms_state_t next_state;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic scl_d;
    logic sda_d;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [7:0] tx;
    logic [7:0] next_tx;
    logic [`IBMS_AW-1:0] addr;
    logic [`IBMS_AW-1:0] next_addr;
    logic [`IBMS_HI_BITS-1:0] addr_hi;
    logic [`IBMS_HI_BITS-1:0] next_addr_hi;
    logic mack;
    logic next_mack;
    logic ack_given;
    logic next_ack_given;
    logic next_oe;
    logic [7:0] mem [0:`IBMS_DEPTH-1];
    ibms_pkg::ibms_wr_t wr_in;
    ibms_pkg::ibms_wr_t wr_out;
    logic fifo_in_ready;
    logic fifo_out_valid;

    // ***************************************
    // Pin synchronisers
    // ***************************************
    // Every pin passes two flops; only sync2 and later are decoded
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sync1 <= 6'h3F;
            sync2 <= 6'h3F;
        end else begin
            sync1 <= {select_strap_bit2, select_strap_bit1,
                      select_strap_bit0, write_lock, sda_in, scl};
            sync2 <= sync1;
        end
    end

    // Delayed copy of synchronised clock and data for edge finding
    always_ff @(posedge clk) begin
        if (!rstn) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= sync2[0];
            sda_d <= sync2[1];
        end
    end

    // ***************************************
    // Line event decode
    // ***************************************
    wire scl_s = sync2[0];
    wire sda_s = sync2[1];
    wire lock_s = sync2[2];
    wire [2:0] strap_s = sync2[5:3];
    // Sample only on clock rise; data is stable then by master contract
    wire scl_rise = scl_s && !scl_d;
    wire scl_fall = !scl_s && scl_d;
    // Data edges with the clock held high are start and stop
    wire start_det = scl_s && scl_d && sda_d && !sda_s;
    wire stop_det = scl_s && scl_d && !sda_d && sda_s;
    wire idle = (state == ibms_pkg::ST_IDLE);

    // ***************************************
    // Byte phase decode
    // ***************************************
    // Eighth bit completed: acknowledge decision is made on this fall
    wire byte_done = scl_fall && (cnt == `IBMS_BIT_LAST);
    // Ninth clock completed: acknowledge slot ends on this fall
    wire ack_end = scl_fall && (cnt == `IBMS_ACK_BIT);
    // Type code then straps in high-to-low order
    wire type_ok = (shreg[7:4] == `IBMS_TYPE_CODE);
    wire strap_ok = (shreg[3:1] == strap_s);
    wire addr_match = type_ok && strap_ok;
    wire dir_read = shreg[0];
    wire in_dev = (state == ibms_pkg::ST_DEV);
    wire in_wdata = (state == ibms_pkg::ST_WDATA);
    wire in_rdata = (state == ibms_pkg::ST_RDATA);

    // ***************************************
    // Memory path decode
    // ***************************************
    // Fetch next read byte after read word or after master acknowledge
    wire load_tx = ack_end && ((in_dev && dir_read) || (in_rdata && mack));
    // Write commits once its acknowledge slot closes, unless locked
    wire push = ack_end && in_wdata && ack_given && !lock_s;
    // Counter moves past every byte written or read
    wire addr_inc = load_tx || (ack_end && in_wdata && ack_given);
    wire [`IBMS_AW-1:0] addr_plus = addr + 1'b1;
    wire [7:0] mem_rd = mem[addr];
    wire drain = fifo_out_valid && !load_tx;
    assign wr_in.addr = addr;
    assign wr_in.data = shreg;

    // ***************************************
    // Write buffer
    // ***************************************
    // Drain stalls in a fetch cycle so the array has one port
    ibms_fifo #(
        .WIDTH($bits(ibms_pkg::ibms_wr_t)),
        .DEPTH(`IBMS_FIFO_DEPTH)
    ) u_wbuf (
        .clk(clk),
        .rstn(rstn),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(wr_in),
        .out_valid(fifo_out_valid),
        .out_ready(!load_tx),
        .out_data(wr_out)
    );

    // Array is not reset, its content is retained data
    always_ff @(posedge clk) begin
        if (drain) begin
            mem[wr_out.addr] <= wr_out.data;
        end
    end

    // ***************************************
    // Serial sequencer
    // ***************************************
    // Stop beats start; both override whatever phase is running
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_tx = tx;
        next_addr = addr;
        next_addr_hi = addr_hi;
        next_mack = mack;
        next_ack_given = ack_given;
        next_oe = sda_oe;
        if (stop_det) begin
            // Ends any transfer, even mid byte or before acknowledge
            next_state = ibms_pkg::ST_IDLE;
            next_oe = 1'b0;
        end else if (start_det) begin
            // Fresh or repeated start always takes a new address word
            next_state = ibms_pkg::ST_DEV;
            // Clock fall that closes the start is no bit; it wraps the count to zero
            next_cnt = `IBMS_BIT_ARMED;
            next_oe = 1'b0;
        end else if (!idle) begin
            if (scl_rise) begin
                if (cnt < `IBMS_ACK_BIT) begin
                    next_shreg = {shreg[6:0], sda_s};
                end else begin
                    // Master pulls low to ask for another byte
                    next_mack = !sda_s;
                end
            end
            if (scl_fall) begin
                if (cnt == `IBMS_BIT_LAST) begin
                    next_cnt = `IBMS_ACK_BIT;
                    case (state)
                        ibms_pkg::ST_DEV: begin
                            if (addr_match) begin
                                next_oe = 1'b1;
                            end else begin
                                next_state = ibms_pkg::ST_IDLE;
                            end
                        end
                        ibms_pkg::ST_AHI,
                        ibms_pkg::ST_ALO: begin
                            next_oe = 1'b1;
                        end
                        ibms_pkg::ST_WDATA: begin
                            // A full buffer refuses the byte with no acknowledge
                            next_ack_given = fifo_in_ready;
                            next_oe = fifo_in_ready;
                        end
                        ibms_pkg::ST_RDATA: begin
                            next_oe = 1'b0;
                        end
                        default: begin
                            next_state = ibms_pkg::ST_IDLE;
                        end
                    endcase
                end else if (cnt == `IBMS_ACK_BIT) begin
                    next_cnt = 4'h0;
                    next_oe = 1'b0;
                    case (state)
                        ibms_pkg::ST_DEV: begin
                            if (dir_read) begin
                                next_state = ibms_pkg::ST_RDATA;
                            end else begin
                                next_state = ibms_pkg::ST_AHI;
                            end
                        end
                        ibms_pkg::ST_AHI: begin
                            // Top three bits are zero by master contract
                            next_addr_hi = shreg[`IBMS_HI_BITS-1:0];
                            next_state = ibms_pkg::ST_ALO;
                        end
                        ibms_pkg::ST_ALO: begin
                            next_addr = {addr_hi, shreg};
                            next_state = ibms_pkg::ST_WDATA;
                        end
                        ibms_pkg::ST_WDATA: begin
                            if (!ack_given) begin
                                next_state = ibms_pkg::ST_IDLE;
                            end
                        end
                        ibms_pkg::ST_RDATA: begin
                            if (!mack) begin
                                next_state = ibms_pkg::ST_IDLE;
                            end
                        end
                        default: begin
                            next_state = ibms_pkg::ST_IDLE;
                        end
                    endcase
                    if (load_tx) begin
                        // First bit goes out right after the fall
                        next_tx = mem_rd;
                        next_oe = !mem_rd[7];
                    end
                    if (addr_inc) begin
                        next_addr = addr_plus;
                    end
                end else begin
                    next_cnt = cnt + 4'h1;
                    if (in_rdata) begin
                        next_tx = {tx[6:0], 1'b0};
                        next_oe = !tx[6];
                    end
                end
            end
        end
    end

    // ***************************************
    // Sequencer registers
    // ***************************************
    // Phase and counters
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= ibms_pkg::ST_IDLE;
            cnt <= 4'h0;
            mack <= 1'b0;
            ack_given <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            mack <= next_mack;
            ack_given <= next_ack_given;
        end
    end

    // Shifters and address counter
    always_ff @(posedge clk) begin
        if (!rstn) begin
            shreg <= 8'h00;
            tx <= 8'h00;
            addr <= 13'h0000;
            addr_hi <= 5'h00;
        end else begin
            shreg <= next_shreg;
            tx <= next_tx;
            addr <= next_addr;
            addr_hi <= next_addr_hi;
        end
    end

    // ***************************************
    // Pin drivers
    // ***************************************
    // Open drain: drive value held low, only the enable moves
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            busy <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            sda_oe <= next_oe;
            busy <= (next_state != ibms_pkg::ST_IDLE);
        end
    end

    // ***************************************
    // Checks
    // ***************************************
    AST_NEVER_HIGH: assert property (@(posedge clk) disable iff (!rstn)
        sda_out == 1'b0)
        else $error("data line driven high");

    AST_OE_AFTER_FALL: assert property (@(posedge clk) disable iff (!rstn)
        $changed(sda_oe) |-> $past(scl_fall || start_det || stop_det))
        else $error("drive changed away from a clock fall");

    AST_START_ADDR: assert property (@(posedge clk) disable iff (!rstn)
        start_det && !stop_det |=> in_dev && cnt == `IBMS_BIT_ARMED && !sda_oe)
        else $error("start did not open an address word");

    AST_STOP_STANDBY: assert property (@(posedge clk) disable iff (!rstn)
        stop_det |=> idle && !sda_oe ##1 !sda_oe)
        else $error("stop did not return to standby");

    AST_BAD_ADDR: assert property (@(posedge clk) disable iff (!rstn)
        byte_done && in_dev && !addr_match && !start_det && !stop_det
        |=> idle && !sda_oe)
        else $error("foreign address word answered");

    AST_ADDR_ACK: assert property (@(posedge clk) disable iff (!rstn)
        byte_done && in_dev && addr_match && !start_det && !stop_det
        |=> sda_oe && cnt == `IBMS_ACK_BIT)
        else $error("matching address word not acknowledged");

    AST_LOCK_NO_PUSH: assert property (@(posedge clk) disable iff (!rstn)
        lock_s && !fifo_out_valid |=> !fifo_out_valid)
        else $error("write queued while locked");

    AST_WRAP: assert property (@(posedge clk) disable iff (!rstn)
        addr_inc && addr == `IBMS_LAST_ADDR && !start_det && !stop_det
        |=> addr == 13'h0000)
        else $error("address counter did not wrap");

    AST_READ_RELEASE: assert property (@(posedge clk) disable iff (!rstn)
        byte_done && in_rdata && !start_det && !stop_det |=> !sda_oe)
        else $error("read byte not released for acknowledge");

    AST_COMMIT: assert property (@(posedge clk) disable iff (!rstn)
        push |=> ##[0:16] !fifo_out_valid)
        else $error("written byte not committed in time");
endmodule : ibms_slave
`default_nettype wire

// ---- hdl/ibms_cfg.svh ----
// Purpose: constants of the two-wire byte memory slave
// Assumes: one 10 MHz clock, serial clock sampled as a plain pin
// Notes: included by the package and by the top module
//
// Summary of operation
// - Storage is 8192 bytes reached through one address counter.
// - Sample data on serial clock rise, change driven data after its fall.
// - Data line is only pulled low or released, never driven high.
// - Start condition makes the slave expect a new address word.
// - Stop condition finishes any read or write and returns to standby.
// - Transmitter releases on the ninth clock, receiver pulls low to acknowledge.
// - Stop before the acknowledge abandons the operation and enters standby.
// - After a not-acknowledge the slave releases; master then sends stop or start.
// - Upper four address word bits must be type code 1010.
// - Next three bits must match straps two, one, zero in that order.
// - Eighth address word bit selects write when zero, read when one.
// - Wrong type code or strap mismatch gives no response and standby.
// - Write address word is followed by high then low address byte, each acknowledged.
// - Byte write is address word, two address bytes, one data byte, stop.
// - Further data bytes go to following addresses, wrapping to zero.
// - Each byte commits after its acknowledge; no busy time after stop.
// - Write lock high blocks all writes; reads stay allowed.
// - Read sends eight data bits then releases to sample master acknowledge.
// - Read without address bytes returns the byte after the last accessed.
// - Address counter wraps to zero past the end, undefined at power-up; here reset loads it with zero.
// - Random read is address set as for write, repeated start, read word.
`ifndef IBMS_CFG_SVH
`define IBMS_CFG_SVH
`define IBMS_TYPE_CODE 4'hA
`define IBMS_AW 13
`define IBMS_DEPTH 8192
`define IBMS_LAST_ADDR 13'h1FFF
`define IBMS_HI_BITS 5
`define IBMS_FIFO_DEPTH 8
`define IBMS_BIT_LAST 4'h7
`define IBMS_ACK_BIT 4'h8
`define IBMS_BIT_ARMED 4'hF
`endif

// ---- hdl/ibms_pkg.sv ----
// Purpose: shared types of the two-wire byte memory slave
// Assumes: constants come from the cfg header
// Notes: no timing or offsets live here
`default_nettype none
`include "ibms_cfg.svh"
package ibms_pkg;
    // Transfer phases of the serial slave
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_AHI,
        ST_ALO,
        ST_WDATA,
        ST_RDATA
    } ibms_state_t;

    // One committed write travelling through the buffer
    typedef struct packed {
        logic [`IBMS_AW-1:0] addr;
        logic [7:0] data;
    } ibms_wr_t;
endpackage : ibms_pkg
`default_nettype wire

// ---- hdl/ibms_fifo.sv ----
// Purpose: small flip-flop FIFO with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes: full and empty come from pointers with one extra wrap bit
`timescale 1ns/1ps
`default_nettype none
module ibms_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    input wire logic clk, // System clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word
    input wire logic [WIDTH-1:0] in_data, // Offered word
    output logic out_valid, // Word waiting
    input wire logic out_ready, // Drain side takes word
    output logic [WIDTH-1:0] out_data // Oldest word
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PW:0] wp;
    logic [PW:0] rp;

    // ***************************************
    // Status decode
    // ***************************************
    wire full = (wp[PW] != rp[PW]) && (wp[PW-1:0] == rp[PW-1:0]);
    wire empty = (wp == rp);
    wire do_wr = in_valid && !full;
    wire do_rd = out_valid && out_ready;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = store[rp[PW-1:0]];

    // Storage has no reset; only pointers define content
    always_ff @(posedge clk) begin
        if (do_wr) begin
            store[wp[PW-1:0]] <= in_data;
        end
    end

    // Pointer update
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wp <= '0;
            rp <= '0;
        end else begin
            wp <= do_wr ? wp + 1'b1 : wp;
            rp <= do_rd ? rp + 1'b1 : rp;
        end
    end

    // Refused word leaves the write pointer alone
    AST_FIFO_REFUSE: assert property (@(posedge clk) disable iff (!rstn)
        in_valid && !in_ready |=> wp == $past(wp))
        else $error("fifo took a word while full");
endmodule : ibms_fifo
`default_nettype wire

// ---- dv/ibms_master_model.sv ----
// Purpose: two-wire bus master model that drives the slave in the bench
// Assumes: one serial bit is 8 clk, clock low 4 clk and high 4 clk
// Notes: open drain, the model only pulls the data wire low or lets go
`timescale 1ns/1ps
`default_nettype none
module ibms_master_model (
    input wire logic clk, // System clock
    input wire logic sda_line, // Resolved data wire
    output logic scl, // Serial clock, high while idle
    output logic sda_pull // High pulls data low
);
    // Bus idles released, clock standing high between frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // ****************************************
    // Bus primitives
    // ****************************************
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_clk

    // Data moves one clk after the fall so it never races the clock edge
    task automatic bit_cycle(input logic b, output logic r);
        sda_pull <= !b;
        wait_clk(3);
        scl <= 1'b1;
        wait_clk(3);
        r = sda_line;
        wait_clk(1);
        scl <= 1'b0;
        wait_clk(1);
    endtask : bit_cycle

    // Also serves as repeated start when entered with the clock low
    task automatic start_cond();
        sda_pull <= 1'b0;
        wait_clk(4);
        scl <= 1'b1;
        wait_clk(4);
        sda_pull <= 1'b1;
        wait_clk(4);
        scl <= 1'b0;
        wait_clk(1);
    endtask : start_cond

    task automatic stop_cond();
        sda_pull <= 1'b1;
        wait_clk(4);
        scl <= 1'b1;
        wait_clk(4);
        sda_pull <= 1'b0;
        wait_clk(4);
    endtask : stop_cond

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_cycle(b[i], r);
        bit_cycle(1'b1, r);
        ack = !r;
    endtask : send_byte

    // Last byte of a read is refused so the slave lets go
    task automatic read_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, r);
            d[i] = r;
        end
        bit_cycle(!ack, r);
    endtask : read_byte
endmodule : ibms_master_model
`default_nettype wire

// ---- dv/ibms_slave_tb_top.sv ----
// Purpose: self-checking bench of the two-wire byte memory slave
// Assumes: master model drives the link at 800 ns per serial bit
// Notes: expected bytes come from a reference copy of the array
`timescale 1ns/1ps
`default_nettype none
module ibms_slave_tb_top;
    logic clk, rstn, scl, sda_pull, sda_oe, sda_out, busy, write_lock, ack;
    logic [2:0] strap;
    logic [7:0] rd, w;
    logic [12:0] a;
    logic [7:0] ref_mem [int];
    int n_mismatch = 0;
    int check_count = 0;
    int seed = 65;
    int cycles = 0;
    wire logic sda_line;

    // Open-drain wire with pull-up
    assign sda_line = !(sda_oe && !sda_out) && !sda_pull;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ibms_slave ibms_slave_i (.clk(clk), .rstn(rstn), .scl(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .select_strap_bit0(strap[0]),
        .select_strap_bit1(strap[1]), .select_strap_bit2(strap[2]),
        .write_lock(write_lock), .busy(busy));
    ibms_master_model ibms_master_model_i (.clk(clk), .sda_line(sda_line), .scl(scl),
        .sda_pull(sda_pull));

    // ****************************************
    // Checking and transfer tasks
    // ****************************************
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [7:0] dev_word(input logic rw);
        return {4'hA, strap, rw};
    endfunction : dev_word

    task automatic put(input logic [7:0] b, input logic exp_ack);
        ibms_master_model_i.send_byte(b, ack);
        check(16'(ack), 16'(exp_ack));
    endtask : put

    task automatic finish_frame();
        ibms_master_model_i.stop_cond();
        check(16'(busy), 16'h0000);
        check(16'(sda_oe), 16'h0000);
    endtask : finish_frame

    task automatic addr_set(input logic [12:0] adr);
        ibms_master_model_i.start_cond();
        put(dev_word(1'b0), 1'b1);
        check(16'(busy), 16'h0001);
        put({3'h0, adr[12:8]}, 1'b1);
        put(adr[7:0], 1'b1);
    endtask : addr_set

    task automatic write_seq(input logic [12:0] adr, input int n, input logic locked);
        logic [7:0] wd;
        addr_set(adr);
        for (int i = 0; i < n; i++) begin
            wd = 8'($random(seed));
            put(wd, 1'b1);
            if (!locked) ref_mem[int'(13'(adr + i))] = wd;
        end
        finish_frame();
    endtask : write_seq

    // Unaddressed reads start from the counter, adr is where it should be
    task automatic read_seq(input logic [12:0] adr, input int n, input logic addressed);
        if (addressed) addr_set(adr);
        ibms_master_model_i.start_cond();
        put(dev_word(1'b1), 1'b1);
        for (int i = 0; i < n; i++) begin
            ibms_master_model_i.read_byte(i < n - 1, rd);
            check(16'(rd), 16'(ref_mem[int'(13'(adr + i))]));
        end
        finish_frame();
    endtask : read_seq

    // Hang guard, about four times the expected run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    // The slave may only pull the wire low
    always @(posedge clk) if (sda_oe === 1'b1) check(16'(sda_out), 16'h0000);

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rstn = 1'b0;
        write_lock = 1'b0;
        strap = 3'($random(seed));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        // Random spot, read back addressed then from the counter
        a = 13'($random(seed));
        write_seq(a, 2, 1'b0);
        read_seq(a, 1, 1'b1);
        read_seq(13'(a + 1), 1, 1'b0);
        $display("test plain write done");
        // Page write and read across the top of the array
        write_seq(13'h1FFE, 5, 1'b0);
        read_seq(13'h1FFE, 4, 1'b1);
        read_seq(13'h0002, 1, 1'b0);
        $display("test wrap done");
        // Locked write is acknowledged, reads still work while locked
        write_lock <= 1'b1;
        write_seq(13'h1FFF, 3, 1'b1);
        read_seq(13'h1FFF, 2, 1'b1);
        write_lock <= 1'b0;
        $display("test lock done");
        // Strap mismatches and foreign type codes get no answer
        for (int i = 0; i < 5; i++) begin
            w = {4'hA, strap ^ 3'(1 << i), 1'b0};
            if (i > 2) w = {4'(i * 2 + 5), strap, 1'b1};
            ibms_master_model_i.start_cond();
            put(w, 1'b0);
            check(16'(busy), 16'h0000);
            finish_frame();
        end
        $display("test refusal done");
        // Stop and repeated start cutting into a byte
        ibms_master_model_i.start_cond();
        put(dev_word(1'b0), 1'b1);
        repeat (3) ibms_master_model_i.bit_cycle(1'b1, ack);
        finish_frame();
        ibms_master_model_i.start_cond();
        put(dev_word(1'b0), 1'b1);
        repeat (4) ibms_master_model_i.bit_cycle(1'b0, ack);
        write_seq(a ^ 13'h0100, 1, 1'b0);
        read_seq(a ^ 13'h0100, 1, 1'b1);
        $display("test abort done");
        conclude();
    end
endmodule : ibms_slave_tb_top
`default_nettype wire
